// ==== core/demc_regs.vh ====
// Offsets, field positions and reset values of the monitor control register
`ifndef DEMC_REGS_VH
`define DEMC_REGS_VH
`define DEMC_CTRL_INDEX 32'he000edfc
`define DEMC_CTRL_ADDR 32'he000edfc
`define DEMC_BIT_TRACE_EN 24
`define DEMC_BIT_SEC_MON 20
`define DEMC_BIT_MON_SEM 19
`define DEMC_BIT_MONITOR_SINGLE_STEP 18
`define DEMC_BIT_MONITOR_PEND_CTL 17
`define DEMC_BIT_MONITOR_EXCEPTION_ENABLE 16
`define DEMC_BIT_CATCH_SEC 11
`define DEMC_CATCH_HI 10
`define DEMC_CATCH_LO 4
`define DEMC_BIT_CATCH_RST 0
`define DEMC_COLD_RESET 10'h000
`define DEMC_WARM_RESET 4'h0
`endif

// ==== core/demc_control.v ====
// Debug exception and monitor control register with its consumers' gating
//
// Function
// R01: Bit 24 is one global enable for watchpoint and instrumentation trace.
// R02: Register is a 32-bit read/write word; unprivileged accesses fault.
// R03: Software clears features, drains trace, then clears global enable.
// R04: Software should set global enable when external trace macrocell used.
// R05: Cold reset clears global trace enable and every vector catch enable.
// R06: Warm reset clears monitor semaphore, step, pend and enable bits.
// R07: Bit 20 selects secure monitor target and secure debug events.
// R08: Bit 20 tracks allowed condition unless monitor pending or active.
// R09: Bit 20 is read-only and zero without security or main extension.
// R10: Bit 19 is a plain semaphore with no effect on the processor.
// R11: Bit 18 enables single stepping through the monitor exception.
// R12: Step writes defined only at sufficient priority or zero-over-zero.
// R13: Writing pend 1 pends monitor exception; writing 0 clears pending.
// R14: Pend works regardless of the monitor enable bit.
// R15: Bit 16 enables monitor exception; ignored when event halts instead.
// R16: With bit 20 set, enable reads zero and ignores non-secure writes.
// R17: Bit 11 traps secure faults unless halting or secure debug is off.
// R18: Bits 10 to 4 catch hard, context, bus, state, check, coproc, memory.
// R19: Bits 10 to 4 ignored without halting debug or secure-targeted no-SDE.
// R20: Bit 0 enables reset vector catch, halting on a Warm reset.
// R21: Reset catch ignored without halting debug; else Warm reset pends catch.
// R22: Reserved bits read as zero and ignore writes.
`timescale 1ns/10ps
`include "demc_regs.vh"

module demc_control #(
  parameter HAS_SECURITY = 1,
  parameter HAS_MAIN = 1
) (
  input wire i_clock,
  input wire i_rst_n,
  input wire i_warm_rst_n,
  input wire [31:0] i_addr,
  input wire [31:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  input wire i_privileged,
  input wire i_nonsecure,
  input wire i_prio_at_or_above_mon,
  input wire i_sec_mon_allowed,
  input wire i_mon_pending_or_active,
  input wire i_mon_taken,
  input wire i_halting_debug_on,
  input wire i_halting_allowed,
  input wire i_secure_debug_on,
  input wire i_exc_targets_secure,
  input wire i_event_halts,
  output reg [31:0] o_rdata,
  output reg o_bus_fault,
  output reg o_trace_global_enable,
  output reg o_secure_monitor_select,
  output reg o_monitor_single_step,
  output reg o_monitor_pend,
  output reg o_monitor_enable_eff,
  output reg o_catch_secure_fault_eff,
  output reg [6:0] o_catch_fault_eff,
  output reg o_catch_core_reset_eff
);

  //////////////////////////////////////////////////////////////////////////////
  // Storage
  reg trace_en_q;
  reg sec_mon_q;
  reg mon_sem_q;
  reg monitor_single_step_q;
  reg monitor_pend_ctl_q;
  reg monitor_exception_enable_q;
  reg catch_sec_q;
  reg [6:0] catch_q;
  reg catch_rst_q;

  // Next values of the stored fields
  reg trace_en_d;
  reg sec_mon_d;
  reg mon_sem_d;
  reg monitor_single_step_d;
  reg monitor_pend_ctl_d;
  reg monitor_exception_enable_d;
  reg catch_sec_d;
  reg [6:0] catch_d;
  reg catch_rst_d;

  // Outputs are registered, one cycle behind the storage and inputs they are derived from
  reg [31:0] rdata_d;
  reg bus_fault_d;
  reg trace_out_d;
  reg sec_mon_out_d;
  reg step_out_d;
  reg pend_out_d;
  reg en_eff_d;
  reg catch_sec_eff_d;
  reg catch_rst_eff_d;
  wire [6:0] catch_fault_eff_d;

  // Register image as software sees it
  reg [31:0] image;
  wire rd_ok;
  wire en_visible;
  wire fault_gate;
  // Whole-word accesses only; byte lanes are not decoded
  localparam CATCH_W = `DEMC_CATCH_HI - `DEMC_CATCH_LO + 1;
  genvar g;

  wire hit = (i_addr == `DEMC_CTRL_ADDR);
  wire ok = hit && i_privileged;
  wire wr_ok = i_wr && ok;
  wire sec_ok = (HAS_SECURITY != 0) && (HAS_MAIN != 0);
  wire halt_ok = i_halting_debug_on && i_halting_allowed;
  // Non-secure writers cannot touch enable while secure monitor selected
  wire en_wr_ok = wr_ok && !(sec_mon_q && i_nonsecure); // R16
  // Undefined step writes are ignored, the safest constrained choice
  wire step_wr_ok = wr_ok && (i_prio_at_or_above_mon ||
                    (!monitor_single_step_q && !i_wdata[`DEMC_BIT_MONITOR_SINGLE_STEP])); // R12

  //////////////////////////////////////////////////////////////////////////////
  // Cold-reset fields, next values
  // Catch enables deliberately survive a warm reset
  always @* begin
    trace_en_d = trace_en_q;
    catch_sec_d = catch_sec_q;
    catch_d = catch_q;
    catch_rst_d = catch_rst_q;
    if (wr_ok) begin
      trace_en_d = i_wdata[`DEMC_BIT_TRACE_EN]; // R01
      // No storage for the secure fault catch without both extensions
      catch_sec_d = sec_ok & i_wdata[`DEMC_BIT_CATCH_SEC]; // R17
      catch_d = i_wdata[`DEMC_CATCH_HI:`DEMC_CATCH_LO]; // R18
      catch_rst_d = i_wdata[`DEMC_BIT_CATCH_RST]; // R20
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Cold-reset storage
  always @(posedge i_clock) begin
    if (!i_rst_n) begin
      {trace_en_q, catch_sec_q, catch_q, catch_rst_q} <=
        `DEMC_COLD_RESET; // R05
    end else begin
      trace_en_q <= trace_en_d;
      catch_sec_q <= catch_sec_d;
      catch_q <= catch_d;
      catch_rst_q <= catch_rst_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Warm-reset fields, next values; cold reset implies warm
  always @* begin
    mon_sem_d = mon_sem_q;
    monitor_single_step_d = monitor_single_step_q;
    monitor_pend_ctl_d = monitor_pend_ctl_q;
    monitor_exception_enable_d = monitor_exception_enable_q;
    if (wr_ok) begin
      mon_sem_d = i_wdata[`DEMC_BIT_MON_SEM]; // R10
    end
    // Step writes outside the defined cases never reach here
    if (step_wr_ok) begin
      monitor_single_step_d = i_wdata[`DEMC_BIT_MONITOR_SINGLE_STEP]; // R11
    end
    // Pend write independent of enable; write wins over acceptance
    if (wr_ok) begin
      monitor_pend_ctl_d = i_wdata[`DEMC_BIT_MONITOR_PEND_CTL]; // R13 R14
    end else if (i_mon_taken) begin
      monitor_pend_ctl_d = 1'b0;
    end
    if (en_wr_ok) begin
      monitor_exception_enable_d = i_wdata[`DEMC_BIT_MONITOR_EXCEPTION_ENABLE]; // R15
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Warm-reset storage
  always @(posedge i_clock) begin
    if (!i_rst_n || !i_warm_rst_n) begin
      {mon_sem_q, monitor_single_step_q, monitor_pend_ctl_q, monitor_exception_enable_q} <=
        `DEMC_WARM_RESET; // R06
    end else begin
      mon_sem_q <= mon_sem_d;
      monitor_single_step_q <= monitor_single_step_d;
      monitor_pend_ctl_q <= monitor_pend_ctl_d;
      monitor_exception_enable_q <= monitor_exception_enable_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Secure monitor select follows allowed condition only when idle
  // Own pend bit counts as pending before the core reports it
  always @* begin
    sec_mon_d = sec_mon_q;
    if (!sec_ok) begin
      sec_mon_d = 1'b0; // R09
    end else if (!i_mon_pending_or_active && !monitor_pend_ctl_q) begin
      sec_mon_d = i_sec_mon_allowed; // R08 R07
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Secure monitor select storage
  always @(posedge i_clock) begin
    if (!i_rst_n) begin
      sec_mon_q <= 1'b0;
    end else begin
      sec_mon_q <= sec_mon_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read data one cycle later, fault on unprivileged access
  // Non-secure view hides the enable while secure monitor selected
  assign en_visible = monitor_exception_enable_q && !(sec_mon_q && i_nonsecure); // R16
  assign rd_ok = i_rd && ok;

  always @* begin
    image = 32'h00000000; // R22
    image[`DEMC_BIT_TRACE_EN] = trace_en_q;
    image[`DEMC_BIT_SEC_MON] = sec_mon_q; // R09
    image[`DEMC_BIT_MON_SEM] = mon_sem_q;
    image[`DEMC_BIT_MONITOR_SINGLE_STEP] = monitor_single_step_q;
    image[`DEMC_BIT_MONITOR_PEND_CTL] = monitor_pend_ctl_q;
    image[`DEMC_BIT_MONITOR_EXCEPTION_ENABLE] = en_visible; // R16
    image[`DEMC_BIT_CATCH_SEC] = catch_sec_q;
    image[`DEMC_CATCH_HI:`DEMC_CATCH_LO] = catch_q;
    image[`DEMC_BIT_CATCH_RST] = catch_rst_q;
  end

  always @* begin
    // Zero outside the cycle after a read, so nothing stale leaks
    rdata_d = 32'h00000000;
    if (rd_ok) begin
      rdata_d = image;
    end
    bus_fault_d = hit && (i_wr || i_rd) && !i_privileged; // R02
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read port storage
  always @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_rdata <= 32'h00000000;
      o_bus_fault <= 1'b0;
    end else begin
      o_rdata <= rdata_d;
      o_bus_fault <= bus_fault_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Effective controls to the exception and halting logic
  // Gating is registered, so consumers see input changes one cycle late
  assign fault_gate = halt_ok && !((HAS_SECURITY != 0) &&
                      !i_secure_debug_on && i_exc_targets_secure); // R19

  generate
    for (g = 0; g < CATCH_W; g = g + 1) begin : catch_gate_g
      assign catch_fault_eff_d[g] = catch_q[g] && fault_gate; // R19
    end
  endgenerate

  always @* begin
    trace_out_d = trace_en_q; // R01
    sec_mon_out_d = sec_mon_q; // R07
    step_out_d = monitor_single_step_q; // R11
    pend_out_d = monitor_pend_ctl_q; // R13
    en_eff_d = monitor_exception_enable_q && !i_event_halts; // R15
    catch_sec_eff_d = catch_sec_q && halt_ok && i_secure_debug_on; // R17
    // Reset catch stays live even for secure resets without secure debug
    catch_rst_eff_d = catch_rst_q && halt_ok; // R21
  end

  //////////////////////////////////////////////////////////////////////////////
  // Effective control storage
  always @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_trace_global_enable <= 1'b0;
      o_secure_monitor_select <= 1'b0;
      o_monitor_single_step <= 1'b0;
      o_monitor_pend <= 1'b0;
      o_monitor_enable_eff <= 1'b0;
      o_catch_secure_fault_eff <= 1'b0;
      o_catch_fault_eff <= 7'h00;
      o_catch_core_reset_eff <= 1'b0;
    end else begin
      o_trace_global_enable <= trace_out_d;
      o_secure_monitor_select <= sec_mon_out_d;
      o_monitor_single_step <= step_out_d;
      o_monitor_pend <= pend_out_d;
      o_monitor_enable_eff <= en_eff_d;
      o_catch_secure_fault_eff <= catch_sec_eff_d;
      o_catch_fault_eff <= catch_fault_eff_d;
      o_catch_core_reset_eff <= catch_rst_eff_d;
    end
  end

endmodule

// ==== testbench/demc_assertions.sv ====
// Checker on the monitor control register ports
`timescale 1ns/10ps
module demc_assertions (
  input wire i_clock, i_rst_n, i_warm_rst_n, i_wr, i_rd, i_privileged,
  input wire i_mon_pending_or_active, i_halting_debug_on, i_event_halts,
  input wire i_secure_debug_on, i_exc_targets_secure, o_bus_fault,
  input wire o_monitor_pend, o_secure_monitor_select, o_monitor_enable_eff,
  input wire o_catch_secure_fault_eff, o_catch_core_reset_eff,
  input wire [6:0] o_catch_fault_eff,
  input wire [31:0] i_addr, i_wdata, o_rdata
);
  wire hit = i_addr == 32'he000edfc;
  wire acc = (i_wr | i_rd) & hit;
  wire wr_ok = i_wr & hit & i_privileged & i_warm_rst_n;
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  a_read_idle: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
    else $error("read data outside read cycle");
  a_fault_unpriv: assert property (acc & !i_privileged |=> o_bus_fault)
    else $error("no fault on unprivileged access");
  a_fault_cause: assert property (o_bus_fault |-> !$past(i_privileged))
    else $error("fault on privileged access");
  a_pend_write: assert property (
    wr_ok |-> ##2 o_monitor_pend == $past(i_wdata[17], 2))
    else $error("pend output does not follow write");
  a_secmon_hold: assert property (
    i_mon_pending_or_active |-> ##2 $stable(o_secure_monitor_select))
    else $error("secure monitor select moved while pending");
  a_enable_halt: assert property (
    o_monitor_enable_eff |-> !$past(i_event_halts))
    else $error("monitor enable active while halting");
  a_catch_sec: assert property (o_catch_secure_fault_eff |->
    $past(i_secure_debug_on) && $past(i_halting_debug_on))
    else $error("secure fault catch not masked");
  a_catch_fault: assert property (|o_catch_fault_eff |->
    $past(i_halting_debug_on) &&
    !($past(i_exc_targets_secure) && !$past(i_secure_debug_on)))
    else $error("fault catch not masked");
  a_catch_reset: assert property (
    o_catch_core_reset_eff |-> $past(i_halting_debug_on))
    else $error("reset catch not masked");
endmodule
bind demc_control demc_assertions chk_u (.*);

// ==== testbench/demc_core_model.sv ====
// Exception logic model: shows pending state and takes the monitor exception
`timescale 1ns/10ps
module demc_core_model (
  input wire i_clock, i_pend, i_take_en,
  output reg o_pending_or_active = 1'h0,
  output reg o_taken = 1'h0
);
  // Active state lasts until the bench withdraws permission to run it
  always @(posedge i_clock) begin
    o_pending_or_active <= i_pend | (i_take_en & o_pending_or_active);
    o_taken <= i_take_en & i_pend & ~o_taken;
  end
endmodule

// ==== testbench/demc_control_test.sv ====
// Self-checking bench for the monitor control register
`timescale 1ns/10ps
module demc_control_test;
  localparam [31:0] A = 32'he000edfc;
  reg i_clock = 0, i_rst_n = 0, i_warm_rst_n = 1, i_wr = 0, i_rd = 0;
  reg i_privileged = 1, i_nonsecure = 0, i_prio_at_or_above_mon = 1;
  reg i_sec_mon_allowed = 0, i_halting_debug_on = 1, take_en = 0;
  reg [31:0] i_addr = A, i_wdata = 0;
  reg i_halting_allowed = 1, i_secure_debug_on = 1;
  reg i_exc_targets_secure = 1, i_event_halts = 0;
  wire i_mon_pending_or_active, i_mon_taken, o_bus_fault, o_trace_global_enable;
  wire o_secure_monitor_select, o_monitor_single_step, o_monitor_pend;
  wire o_monitor_enable_eff, o_catch_secure_fault_eff, o_catch_core_reset_eff;
  wire [6:0] o_catch_fault_eff;
  wire [31:0] o_rdata;
  integer miscompares = 0, n_compared = 0, k;
  reg [63:0] rows [0:3];
  always #25 i_clock = ~i_clock;
  demc_control dut_u (.*);
  demc_core_model model_u (.i_clock(i_clock), .i_pend(o_monitor_pend),
    .i_take_en(take_en), .o_pending_or_active(i_mon_pending_or_active),
    .o_taken(i_mon_taken));
  task chk(input string nm, input [31:0] e, input [31:0] s);
    n_compared = n_compared + 1;
    if (s !== e) begin
      miscompares = miscompares + 1;
      $display("CHECK FAILED %0s expected %h seen %h", nm, e, s);
    end
  endtask
  task wr(input [31:0] a, input [31:0] d);
    @(posedge i_clock);
    i_wr <= 1'h1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clock);
    i_wr <= 1'h0;
  endtask
  task rd(input [31:0] a, input [31:0] e);
    @(posedge i_clock);
    i_rd <= 1'h1;
    i_addr <= a;
    @(posedge i_clock);
    i_rd <= 1'h0;
    #1 chk("read data", e, o_rdata);
  endtask
  task tally_and_finish;
    if (miscompares == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    rows[0] = {32'hffffffff, 32'h010f0ff1};
    rows[1] = {32'h00000000, 32'h00000000};
    rows[2] = {32'h00020000, 32'h00020000};
    rows[3] = {32'h01010811, 32'h01010811};
    repeat (5) @(posedge i_clock);
    i_rst_n <= 1'h1;
    rd(A, 32'h0);
    for (k = 0; k < 4; k = k + 1) begin
      wr(A, rows[k][63:32]);
      rd(A, rows[k][31:0]);
      chk("outputs", rows[k][31:0] & 32'h01170ff1, {o_trace_global_enable,
        3'h0, o_secure_monitor_select, 1'h0, o_monitor_single_step,
        o_monitor_pend, o_monitor_enable_eff, 4'h0, o_catch_secure_fault_eff,
        o_catch_fault_eff, 3'h0, o_catch_core_reset_eff});
    end
    wr(A, 32'h01000000);
    rd(A, 32'h01000000);
    wr(A, 32'h00000000);
    @(posedge i_clock);
    #1 chk("trace enable", 32'h0, o_trace_global_enable);
    wr(A, 32'hffffffff);
    @(posedge i_clock) i_warm_rst_n <= 1'h0;
    @(posedge i_clock) i_warm_rst_n <= 1'h1;
    rd(A, 32'h01000ff1);
    @(posedge i_clock) i_privileged <= 1'h0;
    wr(A, 32'h0);
    #1 chk("bus fault", 32'h1, o_bus_fault);
    @(posedge i_clock) i_privileged <= 1'h1;
    wr(A ^ 32'h4, 32'h0);
    rd(A ^ 32'h4, 32'h0);
    rd(A, 32'h01000ff1);
    @(posedge i_clock) i_prio_at_or_above_mon <= 1'h0;
    wr(A, 32'h01040ff1);
    rd(A, 32'h01000ff1);
    @(posedge i_clock) i_sec_mon_allowed <= 1'h1;
    @(posedge i_clock) i_nonsecure <= 1'h1;
    wr(A, 32'h01010000);
    rd(A, 32'h01100000);
    @(posedge i_clock) i_nonsecure <= 1'h0;
    rd(A, 32'h01100000);
    wr(A, 32'h00020000);
    @(posedge i_clock) i_sec_mon_allowed <= 1'h0;
    rd(A, 32'h00120000);
    @(posedge i_clock) take_en <= 1'h1;
    repeat (4) @(posedge i_clock);
    rd(A, 32'h00100000);
    @(posedge i_clock) take_en <= 1'h0;
    repeat (2) @(posedge i_clock);
    rd(A, 32'h0);
    // Halting debug off must mask every catch output
    @(posedge i_clock) i_halting_debug_on <= 1'h0;
    wr(A, 32'h00000ff1);
    rd(A, 32'h00000ff1);
    chk("catch", 32'h0, {o_catch_secure_fault_eff, o_catch_fault_eff,
      o_catch_core_reset_eff});
    @(posedge i_clock) i_halting_debug_on <= 1'h1;
    i_secure_debug_on <= 1'h0;
    i_event_halts <= 1'h1;
    wr(A, 32'h00010ff1);
    repeat (2) @(posedge i_clock);
    #1 chk("enable", 32'h0, o_monitor_enable_eff);
    chk("secure catch", 32'h0, o_catch_secure_fault_eff);
    chk("fault catch", 32'h0, o_catch_fault_eff);
    chk("reset catch", 32'h1, o_catch_core_reset_eff);
    @(posedge i_clock) i_halting_allowed <= 1'h0;
    i_exc_targets_secure <= 1'h0;
    i_event_halts <= 1'h0;
    repeat (2) @(posedge i_clock);
    #1 chk("enable", 32'h1, o_monitor_enable_eff);
    chk("fault catch", 32'h0, o_catch_fault_eff);
    chk("reset catch", 32'h0, o_catch_core_reset_eff);
    @(posedge i_clock) i_halting_allowed <= 1'h1;
    repeat (2) @(posedge i_clock);
    #1 chk("fault catch", 32'h7f, o_catch_fault_eff);
    chk("secure catch", 32'h0, o_catch_secure_fault_eff);
    @(posedge i_clock) i_rst_n <= 1'h0;
    @(posedge i_clock) i_rst_n <= 1'h1;
    rd(A, 32'h0);
    tally_and_finish;
  end
endmodule
